/* File: hw/irq_ack_if.sv */
/*
  Link between the peripheral end and the host end: request, acknowledge and
  the data bus, whose level is resolved here from the peripheral's enable.
  Assumes the host never drives the data bus during acknowledge.
*/
`timescale 1ns/1ps
interface irq_ack_if;
  import irq_ack_pkg::*;

  logic       irq_request_n;
  logic       int_ack_in_n;
  logic [7:0] dev_data_out;
  logic       dev_data_oe;
  logic [7:0] data_bus;

  // Undriven bus floats high through the pull-ups
  assign data_bus = dev_data_oe ? dev_data_out : BUS_IDLE;

  modport device_end (
    output irq_request_n,
    output dev_data_out,
    output dev_data_oe,
    input  int_ack_in_n,
    input  data_bus
  );

  modport host_end (
    input  irq_request_n,
    input  data_bus,
    output int_ack_in_n
  );
endinterface

/* File: hw/irq_ack_pkg.sv */
/*
  Shared constants and types for the interrupt request / vector acknowledge link
  between a serial peripheral and an 8-bit host with three interrupt modes.
  Assumes both ends run on one common clock mclk and one reset sys_rst.
*/
package irq_ack_pkg;

  localparam int         COND_COUNT    = 8;
  localparam logic [7:0] MASK_RESET    = 8'h00;
  localparam logic [7:0] VECTOR_RESET  = 8'h00;
  localparam logic [7:0] BUS_IDLE      = 8'hFF;
  localparam logic [7:0] RESTART_MASK  = 8'hC7;
  localparam logic [7:0] RESTART_MATCH = 8'hC7;
  localparam int         RESTART_LSB   = 3;
  localparam int         RESTART_MSB   = 5;
  localparam logic [15:0] DIRECT_ADDR  = 16'h0038;
  localparam logic [7:0] PAGE_ZERO     = 8'h00;

  typedef enum logic [1:0] {
    HOST_MODE_RESTART,
    HOST_MODE_DIRECT,
    HOST_MODE_VECTORED
  } host_mode_t;

  typedef enum logic {
    DEV_IDLE,
    DEV_DRIVE
  } dev_state_t;

  typedef enum logic [2:0] {
    HOST_IDLE,
    HOST_WAIT_INSTR,
    HOST_ANNOUNCE,
    HOST_ACK_CYCLE,
    HOST_SERVICE
  } host_state_t;

endpackage

/* File: hw/irq_host_glue.sv */
/*
  Host end: processor-module glue that derives bus strobes, waits for the end
  of the current instruction, runs the acknowledge sequence in modes 0 and 2 and
  forms the service address for interrupt modes 0, 1 and 2.
  Assumes processor pins and instr_done are synchronous to mclk.
*/
`timescale 1ns/1ps
module irq_host_glue
  import irq_ack_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  irq_ack_if.host_end      bus,
  input  host_mode_t       host_mode,
  input  wire logic [7:0]  page_register,
  input  wire logic        instr_done,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        port_request_n,
  input  wire logic        memory_request_n,
  input  wire logic        fetch_cycle_n,
  output logic             mem_rd_n,
  output logic             mem_wr_n,
  output logic             port_rd_n,
  output logic             port_wr_n,
  output logic             cpu_ack_out_n,
  output logic [15:0]      service_addr,
  output logic             service_valid,
  output logic             bad_opcode
);

  typedef struct packed {
    host_state_t st;
    host_mode_t  mode;
    logic        seq_ack_n;
    logic        ack_n;
    logic [3:0]  strobes_n;
    logic [15:0] addr;
    logic        valid;
    logic        bad;
  } host_regs_t;

  host_regs_t r;
  host_regs_t next_r;
  logic       glue_ack_n;
  logic [7:0] vec;

  always_comb
  begin
    next_r = r;
    next_r.valid = 1'b0;
    next_r.bad = 1'b0;
    vec = bus.data_bus;
    next_r.strobes_n[0] = memory_request_n | rd_n;
    next_r.strobes_n[1] = memory_request_n | wr_n;
    next_r.strobes_n[2] = port_request_n | rd_n | !fetch_cycle_n;
    next_r.strobes_n[3] = port_request_n | wr_n;
    glue_ack_n = port_request_n | fetch_cycle_n;
    case (r.st)
      HOST_IDLE:
      begin
        if (!bus.irq_request_n)
        begin
          next_r.st = HOST_WAIT_INSTR;
          next_r.mode = host_mode;
        end
      end
      HOST_WAIT_INSTR:
      begin
        if (instr_done)
        begin
          if (r.mode == HOST_MODE_DIRECT)
          begin
            next_r.addr = DIRECT_ADDR;
            next_r.valid = 1'b1;
            next_r.st = HOST_SERVICE;
          end
          else
          begin
            next_r.seq_ack_n = 1'b0;
            next_r.st = HOST_ANNOUNCE;
          end
        end
      end
      HOST_ANNOUNCE:
      begin
        next_r.st = HOST_ACK_CYCLE;
      end
      HOST_ACK_CYCLE:
      begin
        next_r.seq_ack_n = 1'b1;
        next_r.valid = 1'b1;
        next_r.st = HOST_SERVICE;
        if (r.mode == HOST_MODE_VECTORED)
        begin
          next_r.addr = {page_register, vec[7:1], 1'b0};
        end
        else
        begin
          next_r.addr = {PAGE_ZERO, 2'b00, vec[RESTART_MSB:RESTART_LSB], 3'b000};
          if ((vec & RESTART_MASK) != RESTART_MATCH)
          begin
            next_r.bad = 1'b1;
            next_r.valid = 1'b0;
          end
        end
      end
      HOST_SERVICE:
      begin
        // The service routine clears the cause before the next request is taken
        if (bus.irq_request_n)
        begin
          next_r.st = HOST_IDLE;
        end
      end
      default:
      begin
        next_r.st = HOST_IDLE;
        next_r.seq_ack_n = 1'b1;
      end
    endcase
    next_r.ack_n = next_r.seq_ack_n & glue_ack_n;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      r.st <= HOST_IDLE;
      r.mode <= HOST_MODE_RESTART;
      r.seq_ack_n <= 1'b1;
      r.ack_n <= 1'b1;
      r.strobes_n <= 4'hF;
      r.addr <= 16'h0000;
      r.valid <= 1'b0;
      r.bad <= 1'b0;
    end
    else if (ce)
    begin
      r <= next_r;
    end
  end

  assign bus.int_ack_in_n = r.ack_n;
  assign cpu_ack_out_n    = r.ack_n;
  assign mem_rd_n         = r.strobes_n[0];
  assign mem_wr_n         = r.strobes_n[1];
  assign port_rd_n        = r.strobes_n[2];
  assign port_wr_n        = r.strobes_n[3];
  assign service_addr     = r.addr;
  assign service_valid    = r.valid;
  assign bad_opcode       = r.bad;

endmodule

/* File: hw/irq_vector_device.sv */
/*
  Peripheral end: latches interrupt conditions, gates them by the mask and, in
  vectored mode, by the priority chain input, raises the active-low request and
  answers a vectored acknowledge with bits 7:1 of the vector register and bit 0 driven as zero.
  Assumes the condition, clear and command inputs are synchronous to mclk and
  that the host holds acknowledge low through the acknowledge cycle.
*/
`timescale 1ns/1ps
module irq_vector_device
  import irq_ack_pkg::*;
#(
  parameter int N = COND_COUNT
)(
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  irq_ack_if.device_end     bus,
  input  wire logic [N-1:0] cond_event,
  input  wire logic [N-1:0] cond_clear,
  input  wire logic         mask_write,
  input  wire logic [N-1:0] mask_data,
  input  wire logic         vector_write,
  input  wire logic [7:0]   vector_data,
  input  wire logic         set_vectored,
  input  wire logic         priority_chain_in,
  output logic              vectored_mode,
  output logic [N-1:0]      pending,
  output logic              vector_served
);

  typedef struct packed {
    dev_state_t   st;
    logic         vmode;
    logic [N-1:0] pend;
    logic [N-1:0] mask;
    logic [7:0]   vector_register;
    logic         irq_n;
    logic         oe;
    logic [7:0]   dout;
    logic         served;
  } dev_regs_t;

  dev_regs_t    r;
  dev_regs_t    next_r;
  logic [N-1:0] next_pend;
  logic         unmasked_any;
  logic         chain_allows;
  logic         ack_seen;

  // A new event in the same cycle as its clear is kept
  for (genvar i = 0; i < N; i++)
  begin : g_pend
    assign next_pend[i] = cond_event[i] | (r.pend[i] & ~cond_clear[i]);
  end

  always_comb
  begin
    next_r = r;
    next_r.served = 1'b0;
    next_r.pend = next_pend;
    unmasked_any = |(r.pend & r.mask);
    // Chain input only exists in vectored mode
    chain_allows = !r.vmode || priority_chain_in;
    ack_seen = r.vmode && !bus.int_ack_in_n && !r.irq_n;
    if (set_vectored)
    begin
      next_r.vmode = 1'b1;
    end
    if (mask_write)
    begin
      next_r.mask = mask_data;
    end
    if (vector_write)
    begin
      next_r.vector_register = vector_data;
    end
    // Released as soon as nothing unmasked is left pending
    next_r.irq_n = !(unmasked_any && chain_allows);
    case (r.st)
      DEV_IDLE:
      begin
        next_r.oe = 1'b0;
        if (ack_seen)
        begin
          // Acknowledge seen: the following cycle carries the vector
          next_r.st = DEV_DRIVE;
          next_r.oe = 1'b1;
          next_r.dout = {r.vector_register[7:1], 1'b0};
        end
      end
      DEV_DRIVE:
      begin
        if (bus.int_ack_in_n)
        begin
          next_r.st = DEV_IDLE;
          next_r.oe = 1'b0;
          next_r.served = 1'b1;
        end
      end
      default:
      begin
        next_r.st = DEV_IDLE;
        next_r.oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      r.st <= DEV_IDLE;
      r.vmode <= 1'b0;
      r.pend <= '0;
      r.mask <= N'(MASK_RESET);
      r.vector_register <= VECTOR_RESET;
      r.irq_n <= 1'b1;
      r.oe <= 1'b0;
      r.dout <= VECTOR_RESET;
      r.served <= 1'b0;
    end
    else if (ce)
    begin
      r <= next_r;
    end
  end

  assign bus.irq_request_n = r.irq_n;
  assign bus.dev_data_oe   = r.oe;
  assign bus.dev_data_out  = r.dout;
  assign vectored_mode     = r.vmode;
  assign pending           = r.pend;
  assign vector_served     = r.served;

endmodule

/* File: verif/irq_ack_props.sv */
/*
  Assertions on the request / acknowledge link signals.
  Assumes one clock mclk and the async active-high reset sys_rst.
*/
`timescale 1ns/1ps
module irq_ack_props
  import irq_ack_pkg::*;
(
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       irq_request_n,
  input wire logic       int_ack_in_n,
  input wire logic [7:0] dev_data_out,
  input wire logic       dev_data_oe,
  input wire logic [7:0] data_bus
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence ack_released;
    dev_data_oe && int_ack_in_n;
  endsequence

  sequence drive_held;
    dev_data_oe ##1 dev_data_oe;
  endsequence

  AST_OE_CAUSE: assert property ($rose(dev_data_oe) |-> $past(!int_ack_in_n && !irq_request_n))
    else $error("bus driven without acknowledge");
  AST_LSB_ZERO: assert property (dev_data_oe |-> !dev_data_out[0])
    else $error("vector bit 0 not zero");
  AST_DROP: assert property (ack_released |=> !dev_data_oe)
    else $error("bus held after acknowledge ended");
  AST_OE_ACK: assert property (dev_data_oe |-> $past(!int_ack_in_n))
    else $error("bus driven outside acknowledge");
  AST_HOLD: assert property (drive_held |-> $stable(dev_data_out))
    else $error("vector changed while driven");
  AST_IDLE_BUS: assert property (!dev_data_oe |-> data_bus == BUS_IDLE)
    else $error("bus not idle when released");
  AST_RESET: assert property ($fell(sys_rst) |-> irq_request_n && !dev_data_oe)
    else $error("link not quiet after reset");
  AST_FELL: assert property ($fell(dev_data_oe) |-> $past(int_ack_in_n))
    else $error("bus released during acknowledge");
endmodule

/* File: verif/vectored_interrupt_acknowledge_tb.sv */
/*
  Self-checking bench joining the device end and the host end.
  Assumes the package and link interface under hw/.
*/
`timescale 1ns/1ps
module vectored_interrupt_acknowledge_tb;
  import irq_ack_pkg::*;
  logic        mclk = 0, sys_rst = 1, ce = 1, mw = 0, vw = 0, sv = 0, chain = 1;
  logic [7:0]  ev = 0, clr = 0, md = 0, vd = 0, page = 0;
  logic        done = 0, rd_n = 1, wr_n = 1, port_req_n = 1, mem_req_n = 1, fetch_n = 1;
  host_mode_t  mode = HOST_MODE_DIRECT;
  logic        vmode, served, mrd, mwr, prd, pwr, cack, valid, bad, irq_n, ack_n;
  logic [7:0]  pend;
  logic [15:0] addr;
  int          failures = 0, compares = 0, acks = 0;
  // Selectors for the bounded waits
  localparam int W_IRQ = 0, W_VALID = 1, W_BAD = 2, W_SERVED = 3;

  always #25 mclk = ~mclk;
  always @(posedge mclk)
    if (cack === 1'b0)
      acks++;

  irq_ack_if link();
  assign irq_n = link.irq_request_n;
  assign ack_n = link.int_ack_in_n;

  irq_ack_props u_irq_ack_props(.mclk(mclk), .sys_rst(sys_rst), .irq_request_n(link.irq_request_n),
    .int_ack_in_n(link.int_ack_in_n), .dev_data_out(link.dev_data_out), .dev_data_oe(link.dev_data_oe),
    .data_bus(link.data_bus));
  irq_vector_device u_irq_vector_device(.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .bus(link),
    .cond_event(ev), .cond_clear(clr), .mask_write(mw), .mask_data(md), .vector_write(vw),
    .vector_data(vd), .set_vectored(sv), .priority_chain_in(chain), .vectored_mode(vmode),
    .pending(pend), .vector_served(served));
  irq_host_glue u_irq_host_glue(.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .bus(link), .host_mode(mode),
    .page_register(page), .instr_done(done), .rd_n(rd_n), .wr_n(wr_n), .port_request_n(port_req_n),
    .memory_request_n(mem_req_n), .fetch_cycle_n(fetch_n), .mem_rd_n(mrd), .mem_wr_n(mwr), .port_rd_n(prd),
    .port_wr_n(pwr), .cpu_ack_out_n(cack), .service_addr(addr), .service_valid(valid), .bad_opcode(bad));

  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Level watched by a bounded wait
  function automatic logic lvl(input int k);
    case (k)
      W_IRQ:   return irq_n;
      W_VALID: return valid;
      W_BAD:   return bad;
      default: return served;
    endcase
  endfunction

  // Bounded wait; running out counts a mismatch and ends the run
  task automatic wait_lvl(input int k, input logic v);
    for (int i = 0; i < 40 && lvl(k) !== v; i++)
      @(negedge mclk);
    if (lvl(k) !== v)
    begin
      chk(lvl(k), v);
      wrap_up;
    end
  endtask

  // Table rows: memory request, port request, rd, wr pins then expected strobes
  task strobes;
    logic [39:0] t;
    t = 40'h57_6B9D_AEFF;
    repeat (5)
    begin
      {mem_req_n, port_req_n, rd_n, wr_n} = t[39:36];
      tick(2);
      chk({mrd, mwr, prd, pwr}, t[35:32]);
      t = t << 8;
    end
    {port_req_n, fetch_n} = 2'b00;
    tick(3);
    chk({ack_n, cack}, 16'h0000);
    {port_req_n, fetch_n} = 2'b11;
    tick(3);
  endtask

  // Clock enable low: a condition and a read strobe must leave both ends unmoved
  task frozen;
    ce = 1'b0;
    ev = 8'h02;
    {mem_req_n, rd_n} = 2'b00;
    tick(3);
    chk({pend, mrd, irq_n}, 10'h003);
    ev = 8'h00;
    {mem_req_n, rd_n} = 2'b11;
    ce = 1'b1;
    tick(2);
    chk({pend, mrd}, 9'h001);
  endtask

  task svc(input host_mode_t m, input logic [15:0] a, input logic b);
    mode = m;
    done = 0;
    acks = 0;
    ev = 8'h01;
    tick(1);
    ev = 0;
    if (!chain)
    begin
      tick(5);
      chk(irq_n, 1);
      chain = 1;
    end
    wait_lvl(W_IRQ, 1'b0);
    tick(3);
    chk(ack_n, 1);
    done = 1;
    if (b)
      wait_lvl(W_BAD, 1'b1);
    else
    begin
      wait_lvl(W_VALID, 1'b1);
      chk(addr, a);
    end
    if (m == HOST_MODE_VECTORED)
      wait_lvl(W_SERVED, 1'b1);
    chk(acks != 0, m != HOST_MODE_DIRECT);
    clr = 8'h01;
    tick(1);
    clr = 0;
    wait_lvl(W_IRQ, 1'b1);
  endtask

  initial
  begin
    repeat (6) @(negedge mclk);
    sys_rst = 0;
    tick(1);
    chk({vmode, irq_n, pend}, 10'h100);
    frozen;
    strobes;
    ev = 8'h01;
    tick(1);
    ev = 0;
    tick(4);
    chk(irq_n, 1);
    mw = 1;
    md = 8'h01;
    tick(1);
    mw = 0;
    svc(HOST_MODE_DIRECT, 16'h0038, 0);
    svc(HOST_MODE_RESTART, 16'h0038, 0);
    {vw, sv} = 2'b11;
    vd = 8'hC7;
    tick(1);
    {vw, sv} = 2'b00;
    chk(vmode, 1);
    svc(HOST_MODE_RESTART, 0, 1);
    vw = 1;
    vd = 8'h5B;
    page = 8'h12;
    chain = 0;
    tick(1);
    vw = 0;
    svc(HOST_MODE_VECTORED, 16'h125A, 0);
    wrap_up;
  end
endmodule
